/* File: verilog/sfcmd_seq.v */
/*
 * Command sequencer of a serial flash: erase, status, write latch,
 * busy output and identification commands.
 * Assumes chip select, serial clock, serial input and write protect
 * arrive from pins; the memory array sits outside behind erase strobes.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sfcmd_defs.vh"

module sfcmd_seq #(
	parameter [7:0] MAKER_CODE    = 8'h5a, // Arbitrary value
	parameter [7:0] MEM_TYPE_CODE = 8'h3c, // Arbitrary value
	parameter [7:0] CAPACITY_CODE = 8'h14, // Arbitrary value
	parameter [7:0] DEVICE_CODE   = 8'h69, // Arbitrary value
	parameter [4:0] TOP_ADDR_BIT  = 5'd19,
	parameter       BYTE_PROG_CYC = `SFC_BYTE_PROG_US * `SFC_CLK_MHZ,
	parameter       SECTOR_CYC    = `SFC_SECTOR_ERASE_US * `SFC_CLK_MHZ,
	parameter       BLOCK_CYC     = `SFC_BLOCK_ERASE_US * `SFC_CLK_MHZ,
	parameter       ARRAY_CYC     = `SFC_ARRAY_ERASE_US * `SFC_CLK_MHZ
) (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_resetn,
	// Serial link pins
	input  wire        i_chip_sel_n,
	input  wire        i_sck,
	input  wire        i_si,
	input  wire        i_write_protect_n,
	output reg         o_so,
	output reg         o_so_oe,
	// Array erase and program strobes
	output reg         o_erase_req,
	output reg  [1:0]  o_erase_kind,
	output reg  [23:0] o_erase_addr,
	output reg         o_prog_req,
	output reg  [23:0] o_prog_addr,
	output reg  [15:0] o_prog_data,
	// Status
	output reg  [7:0]  o_status,
	output reg         o_busy_out_mode
);

	localparam ST_OPCODE = 4'b0001;
	localparam ST_ADDR   = 4'b0010;
	localparam ST_DATA   = 4'b0100;
	localparam ST_IGNORE = 4'b1000;

	localparam [1:0] ER_SECTOR = 2'h0;
	localparam [1:0] ER_BLK32  = 2'h1;
	localparam [1:0] ER_BLK64  = 2'h2;
	localparam [1:0] ER_ARRAY  = 2'h3;

	wire cs_n_s;
	wire sck_s;
	wire si_s;
	wire wp_n_s;

	sfcmd_sync #(.RESET_VAL(1'b1)) u_sync_cs (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_async(i_chip_sel_n), .o_sync(cs_n_s));
	sfcmd_sync #(.RESET_VAL(1'b0)) u_sync_sck (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_async(i_sck), .o_sync(sck_s));
	sfcmd_sync #(.RESET_VAL(1'b0)) u_sync_si (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_async(i_si), .o_sync(si_s));
	sfcmd_sync #(.RESET_VAL(1'b1)) u_sync_wp (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_async(i_write_protect_n), .o_sync(wp_n_s));

	reg        cs_n_q;
	reg        sck_q;
	reg [3:0]  state_q;
	reg [2:0]  bit_q;
	reg [7:0]  shift_q;
	reg [7:0]  opcode_q;
	reg [2:0]  addr_cnt_q;
	reg [23:0] addr_q;
	reg [1:0]  data_cnt_q;
	reg [15:0] data_q;
	reg [7:0]  out_q;
	reg        id_sel_q;
	reg [1:0]  jedec_idx_q;
	reg        wel_q;
	reg        aai_q;
	reg        aai_addr_set_q;
	reg [23:0] aai_addr_q;
	reg [3:0]  bp_q;
	reg        lock_q;
	reg        arm_q;
	reg        busy_out_q;
	reg        t_start;
	reg [31:0] t_load;
	wire       t_busy;

	sfcmd_timer #(.WIDTH(32)) u_timer (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_start(t_start),
		.i_load(t_load), .o_busy(t_busy), .o_done());

	wire sck_rise = sck_s & ~sck_q;
	wire sck_fall = ~sck_s & sck_q;
	wire cs_fall  = ~cs_n_s & cs_n_q;
	wire cs_rise  = cs_n_s & ~cs_n_q;
	wire [7:0] byte_in = {shift_q[6:0], si_s};
	wire byte_done = sck_rise & (bit_q == `SFC_BITS_LAST) & ~cs_n_s;
	wire [7:0] status_w = {lock_q, aai_q, bp_q, wel_q, t_busy};
	wire any_prot = (bp_q != 4'h0);

	// Protection covers the top 64-Kbyte blocks: 2^(level-1) of them
	function prot_hit;
		input [23:0] a;
		input [3:0]  lvl;
		reg   [7:0]  blk;
		reg   [7:0]  nblk;
		reg   [7:0]  top;
		begin
			blk  = a[`SFC_ADDR_MSB:`SFC_BLOCK64_LSB];
			top  = 8'hff >> (`SFC_ADDR_MSB - TOP_ADDR_BIT);
			nblk = (lvl == 4'h0) ? 8'h0 : (8'h1 << (lvl - 4'h1));
			// Levels past eight overflow the block count: they cover everything
			prot_hit = (lvl != 4'h0) && ((lvl > 4'h8) ||
				(({8'h0, blk & top} + {8'h0, nblk}) > {8'h0, top}));
		end
	endfunction

	// valid opcodes in hardware busy mode
	wire aai_hw = aai_q & busy_out_q;
	wire op_valid = ~aai_hw | (byte_in == `SFC_OP_AAI_WORD) |
		(byte_in == `SFC_OP_WRITE_DIS);

	always @(posedge i_clk) begin
		if (!i_resetn) begin
			cs_n_q <= 1'b1;
			sck_q <= 1'b0;
			state_q <= ST_OPCODE;
			bit_q <= 3'h0;
			shift_q <= 8'h0;
			opcode_q <= 8'h0;
			addr_cnt_q <= 3'h0;
			addr_q <= 24'h0;
			data_cnt_q <= 2'h0;
			data_q <= 16'h0;
			out_q <= 8'h0;
			id_sel_q <= 1'b0;
			jedec_idx_q <= 2'h0;
			wel_q <= 1'b0;
			aai_q <= 1'b0;
			aai_addr_set_q <= 1'b0;
			aai_addr_q <= 24'h0;
			bp_q <= 4'hf;
			lock_q <= 1'b0;
			arm_q <= 1'b0;
			busy_out_q <= 1'b0;
			t_start <= 1'b0;
			t_load <= 32'h0;
			o_so <= 1'b0;
			o_so_oe <= 1'b0;
			o_erase_req <= 1'b0;
			o_erase_kind <= ER_SECTOR;
			o_erase_addr <= 24'h0;
			o_prog_req <= 1'b0;
			o_prog_addr <= 24'h0;
			o_prog_data <= 16'h0;
			o_status <= 8'h0;
			o_busy_out_mode <= 1'b0;
		end else begin
			cs_n_q <= cs_n_s;
			sck_q <= sck_s;
			t_start <= 1'b0;
			o_erase_req <= 1'b0;
			o_prog_req <= 1'b0;
			o_status <= status_w;
			o_busy_out_mode <= busy_out_q;

			if (cs_fall) begin
				state_q <= ST_OPCODE;
				bit_q <= 3'h0;
				opcode_q <= 8'h0;
				addr_cnt_q <= 3'h0;
				data_cnt_q <= 2'h0;
			end

			if (sck_rise & ~cs_n_s) begin
				shift_q <= byte_in;
				bit_q <= bit_q + 3'h1;
			end

			if (byte_done) begin
				case (state_q)
				ST_OPCODE: begin
					opcode_q <= byte_in;
					if (!op_valid) begin
						state_q <= ST_IGNORE;
					end else begin
						case (byte_in)
						`SFC_OP_SECTOR_ERASE, `SFC_OP_BLOCK32_ERASE,
						`SFC_OP_BLOCK64_ERASE, `SFC_OP_LEGACY_ID_A,
						`SFC_OP_LEGACY_ID_B: begin
							state_q <= ST_ADDR;
						end
						`SFC_OP_WRITE_EN, `SFC_OP_WRITE_DIS, `SFC_OP_STATUS_ARM,
						`SFC_OP_BUSY_OUT_EN, `SFC_OP_BUSY_OUT_DIS,
						`SFC_OP_ARRAY_ERASE_A, `SFC_OP_ARRAY_ERASE_B: begin
							// Single-byte commands wait for deselect to act
							state_q <= ST_DATA;
						end
						`SFC_OP_AAI_WORD: begin
							state_q <= aai_addr_set_q ? ST_DATA : ST_ADDR;
						end
						`SFC_OP_STATUS_WRITE: begin
							state_q <= ST_DATA;
						end
						`SFC_OP_READ_STATUS: begin
							out_q <= status_w;
							state_q <= ST_DATA;
						end
						`SFC_OP_JEDEC_ID: begin
							out_q <= MAKER_CODE;
							jedec_idx_q <= 2'h1;
							state_q <= ST_DATA;
						end
						default: begin
							state_q <= ST_IGNORE;
						end
						endcase
					end
				end
				ST_ADDR: begin
					addr_q <= {addr_q[15:0], byte_in};
					addr_cnt_q <= addr_cnt_q + 3'h1;
					if (addr_cnt_q == `SFC_ADDR_BYTES - 3'h1) begin
						state_q <= ST_DATA;
						if (opcode_q == `SFC_OP_LEGACY_ID_A ||
							opcode_q == `SFC_OP_LEGACY_ID_B) begin
							out_q <= byte_in[0] ? DEVICE_CODE : MAKER_CODE;
							id_sel_q <= ~byte_in[0];
						end
					end
				end
				ST_DATA: begin
					data_q <= {data_q[7:0], byte_in};
					if (data_cnt_q != 2'h3) begin
						data_cnt_q <= data_cnt_q + 2'h1;
					end
					case (opcode_q)
					`SFC_OP_READ_STATUS: begin
						out_q <= status_w;
					end
					`SFC_OP_JEDEC_ID: begin
						out_q <= (jedec_idx_q == 2'h1) ? MEM_TYPE_CODE :
							(jedec_idx_q == 2'h2) ? CAPACITY_CODE : 8'h0;
						if (jedec_idx_q != 2'h3) begin
							jedec_idx_q <= jedec_idx_q + 2'h1;
						end
					end
					`SFC_OP_LEGACY_ID_A, `SFC_OP_LEGACY_ID_B: begin
						out_q <= id_sel_q ? DEVICE_CODE : MAKER_CODE;
						id_sel_q <= ~id_sel_q;
					end
					default: begin
						out_q <= out_q;
					end
					endcase
				end
				default: begin
					state_q <= ST_IGNORE;
				end
				endcase
			end else if (sck_fall & ~cs_n_s & (bit_q != 3'h0)) begin
				out_q <= {out_q[6:0], 1'b0};
			end

			// Serial output: data phase shifts out, busy mode shows ready
			if (cs_n_s) begin
				o_so_oe <= 1'b0;
				o_so <= 1'b0;
			end else if (state_q == ST_DATA && (opcode_q == `SFC_OP_READ_STATUS ||
				opcode_q == `SFC_OP_JEDEC_ID || opcode_q == `SFC_OP_LEGACY_ID_A ||
				opcode_q == `SFC_OP_LEGACY_ID_B)) begin
				o_so_oe <= 1'b1;
				o_so <= out_q[7];
			end else if (aai_hw) begin
				o_so_oe <= 1'b1;
				o_so <= ~t_busy;
			end else begin
				o_so_oe <= 1'b0;
				o_so <= 1'b0;
			end

			if (cs_rise && state_q != ST_IGNORE && bit_q == 3'h0) begin
				arm_q <= (opcode_q == `SFC_OP_STATUS_ARM);
				case (opcode_q)
				`SFC_OP_BUSY_OUT_EN: busy_out_q <= 1'b1;
				`SFC_OP_BUSY_OUT_DIS: busy_out_q <= 1'b0;
				`SFC_OP_WRITE_EN: wel_q <= 1'b1;
				`SFC_OP_WRITE_DIS: begin
					wel_q <= 1'b0;
					aai_q <= 1'b0;
					aai_addr_set_q <= 1'b0;
				end
				`SFC_OP_STATUS_WRITE: begin
					wel_q <= 1'b0;
					if ((wel_q | arm_q) && data_cnt_q != 2'h0 && !t_busy &&
						!(~wp_n_s & lock_q)) begin
						bp_q <= data_q[`SFC_SR_BP_HI:`SFC_SR_BP_LO];
						lock_q <= data_q[`SFC_SR_LOCK];
					end
				end
				`SFC_OP_SECTOR_ERASE, `SFC_OP_BLOCK32_ERASE, `SFC_OP_BLOCK64_ERASE: begin
					if (wel_q && !t_busy && state_q == ST_DATA &&
						!prot_hit(addr_q, bp_q)) begin
						wel_q <= 1'b0;
						o_erase_req <= 1'b1;
						t_start <= 1'b1;
						if (opcode_q == `SFC_OP_SECTOR_ERASE) begin
							o_erase_kind <= ER_SECTOR;
							o_erase_addr <= {addr_q[23:`SFC_SECTOR_LSB], 12'h0};
							t_load <= SECTOR_CYC;
						end else if (opcode_q == `SFC_OP_BLOCK32_ERASE) begin
							o_erase_kind <= ER_BLK32;
							o_erase_addr <= {addr_q[23:`SFC_BLOCK32_LSB], 15'h0};
							t_load <= BLOCK_CYC;
						end else begin
							o_erase_kind <= ER_BLK64;
							o_erase_addr <= {addr_q[23:`SFC_BLOCK64_LSB], 16'h0};
							t_load <= BLOCK_CYC;
						end
					end
				end
				// whole array only when nothing protected
				`SFC_OP_ARRAY_ERASE_A, `SFC_OP_ARRAY_ERASE_B: begin
					if (wel_q && !t_busy && !any_prot) begin
						wel_q <= 1'b0;
						o_erase_req <= 1'b1;
						o_erase_kind <= ER_ARRAY;
						o_erase_addr <= 24'h0;
						t_start <= 1'b1;
						t_load <= ARRAY_CYC;
					end
				end
				// word to even then odd address
				`SFC_OP_AAI_WORD: begin
					if (wel_q && !t_busy && data_cnt_q == 2'h2 &&
						!prot_hit(aai_addr_set_q ? aai_addr_q : addr_q, bp_q)) begin
						o_prog_req <= 1'b1;
						o_prog_addr <= aai_addr_set_q ? aai_addr_q : {addr_q[23:1], 1'b0};
						o_prog_data <= data_q;
						aai_addr_q <= (aai_addr_set_q ? aai_addr_q :
							{addr_q[23:1], 1'b0}) + 24'h2;
						aai_addr_set_q <= 1'b1;
						aai_q <= 1'b1;
						t_start <= 1'b1;
						t_load <= BYTE_PROG_CYC;
					end
				end
				default: begin
					arm_q <= (opcode_q == `SFC_OP_STATUS_ARM);
				end
				endcase
			end
		end
	end

endmodule // sfcmd_seq

`default_nettype wire

/* File: verilog/sfcmd_defs.vh */
/*
 * Constants for the serial flash command sequencer: opcodes, status bit
 * positions, address fields and operation times.
 * Assumes inclusion by bare name from the sequencer's design files.
 */
`ifndef SFCMD_DEFS_VH
`define SFCMD_DEFS_VH

// Opcodes
`define SFC_OP_BUSY_OUT_EN   8'h70
`define SFC_OP_BUSY_OUT_DIS  8'h80
`define SFC_OP_AAI_WORD      8'had
`define SFC_OP_WRITE_DIS     8'h04
`define SFC_OP_WRITE_EN      8'h06
`define SFC_OP_READ_STATUS   8'h05
`define SFC_OP_STATUS_ARM    8'h50
`define SFC_OP_STATUS_WRITE  8'h01
`define SFC_OP_SECTOR_ERASE  8'h20
`define SFC_OP_BLOCK32_ERASE 8'h52
`define SFC_OP_BLOCK64_ERASE 8'hd8
`define SFC_OP_ARRAY_ERASE_A 8'h60
`define SFC_OP_ARRAY_ERASE_B 8'hc7
`define SFC_OP_JEDEC_ID      8'h9f
`define SFC_OP_LEGACY_ID_A   8'h90
`define SFC_OP_LEGACY_ID_B   8'hab

// Status register bit positions
`define SFC_SR_BUSY      0
`define SFC_SR_WEL       1
`define SFC_SR_BP_LO     2
`define SFC_SR_BP_HI     5
`define SFC_SR_AAI       6
`define SFC_SR_LOCK      7

// Address fields and erased byte value
`define SFC_SECTOR_LSB   12
`define SFC_BLOCK32_LSB  15
`define SFC_BLOCK64_LSB  16
`define SFC_ADDR_MSB     23
`define SFC_ERASED_BYTE  8'hff

// Byte count and last bit index
`define SFC_ADDR_BYTES   3'h3
`define SFC_BITS_LAST    3'h7

// Operation times in microseconds and the clock in MHz
`define SFC_BYTE_PROG_US    10
`define SFC_SECTOR_ERASE_US 25000
`define SFC_BLOCK_ERASE_US  25000
`define SFC_ARRAY_ERASE_US  50000
`define SFC_CLK_MHZ         20

`endif

/* File: verilog/sfcmd_sync.v */
/*
 * Two-flop synchroniser for one level from outside the clock domain.
 * Assumes a free-running i_clk; no logic reads the first stage.
 */
`timescale 1ns/100ps
`default_nettype none

module sfcmd_sync #(
	parameter RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire i_clk,
	input  wire i_resetn,
	// Level
	input  wire i_async,
	output reg  o_sync
);

	reg meta_q;

	always @(posedge i_clk) begin
		if (!i_resetn) begin
			meta_q <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule // sfcmd_sync

`default_nettype wire

/* File: verilog/sfcmd_timer.v */
/*
 * Down counter that times one self-timed program or erase operation.
 * Assumes a start pulse with a load value; done pulses once at zero.
 */
`timescale 1ns/100ps
`default_nettype none

module sfcmd_timer #(
	parameter WIDTH = 32
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_resetn,
	// Control
	input  wire             i_start,
	input  wire [WIDTH-1:0] i_load,
	output wire             o_busy,
	output reg              o_done
);

	reg [WIDTH-1:0] count_q;

	assign o_busy = (count_q != {WIDTH{1'b0}});

	always @(posedge i_clk) begin
		if (!i_resetn) begin
			count_q <= {WIDTH{1'b0}};
			o_done  <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				count_q <= i_load;
			end else if (o_busy) begin
				count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
				if (count_q == {{(WIDTH-1){1'b0}}, 1'b1}) begin
					o_done <= 1'b1;
				end
			end
		end
	end

endmodule // sfcmd_timer

`default_nettype wire

/* File: verif/sfcmd_seq_assertions.sv */
/* Concurrent checks on the command sequencer's ports.
   Assumes one clock domain and binding into every sfcmd_seq instance. */
`timescale 1ns/100ps
`default_nettype none

module sfcmd_seq_chk (
	// Clock, reset and pins
	input wire logic        i_clk,
	input wire logic        i_resetn,
	input wire logic        i_chip_sel_n,
	input wire logic        i_write_protect_n,
	input wire logic        o_so_oe,
	// Strobes and status
	input wire logic        o_erase_req,
	input wire logic [1:0]  o_erase_kind,
	input wire logic [23:0] o_erase_addr,
	input wire logic        o_prog_req,
	input wire logic [23:0] o_prog_addr,
	input wire logic [7:0]  o_status
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	oe_idle_a: assert property (i_chip_sel_n [*6] |-> !o_so_oe)
		else $error("serial output driven while deselected");
	erase_gate_a: assert property (o_erase_req |-> o_status[1] && !o_status[0])
		else $error("erase started without latch or while busy");
	erase_busy_a: assert property (o_erase_req |-> ##[1:3] o_status[0])
		else $error("busy not raised after erase");
	sector_align_a: assert property (o_erase_req && o_erase_kind == 2'h0 |-> o_erase_addr[11:0] == 12'h000)
		else $error("sector base not aligned");
	blk32_align_a: assert property (o_erase_req && o_erase_kind == 2'h1 |-> o_erase_addr[14:0] == 15'h0000)
		else $error("32K block base not aligned");
	blk64_align_a: assert property (o_erase_req && o_erase_kind == 2'h2 |-> o_erase_addr[15:0] == 16'h0000)
		else $error("64K block base not aligned");
	array_guard_a: assert property (o_erase_req && o_erase_kind == 2'h3 |-> o_status[5:2] == 4'h0)
		else $error("array erase while protected");
	word_even_a: assert property (o_prog_req |-> !o_prog_addr[0] ##[1:3] o_status[0])
		else $error("word program odd or not busy");
	wdis_clear_a: assert property ($fell(o_status[6]) |-> !o_status[1])
		else $error("auto-increment cleared with latch still set");
	lock_hold_a: assert property (!i_write_protect_n [*6] |=> !$fell(o_status[7]))
		else $error("lock bit cleared while protect pin low");

	c_array: cover property (o_erase_req && o_erase_kind == 2'h3);
	c_word: cover property (o_prog_req);
	c_lock: cover property ($rose(o_status[7]));
endmodule // sfcmd_seq_chk

bind sfcmd_seq sfcmd_seq_chk sfcmd_seq_chk_i (.i_clk, .i_resetn, .i_chip_sel_n,
	.i_write_protect_n, .o_so_oe, .o_erase_req, .o_erase_kind, .o_erase_addr,
	.o_prog_req, .o_prog_addr, .o_status);

`default_nettype wire

/* File: verif/sfcmd_host.sv */
/* Host controller model: chip select, serial clock and data in.
   Assumes the bench clock; the serial clock rests low between frames. */
`timescale 1ns/100ps
`default_nettype none

module sfcmd_host (
	// Bench clock and wire
	input  wire logic i_clk,
	input  wire logic i_so,
	// Pins towards the device
	output logic      o_cs_n,
	output logic      o_sck,
	output logic      o_si
);
	logic [7:0] rx;

	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_si = 1'b0;
		rx = 8'h00;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	task automatic sel();
		wt(2);
		o_cs_n = 1'b0;
		wt(6);
	endtask

	task automatic desel();
		wt(4);
		o_cs_n = 1'b1;
		// Released data line must not keep its last level
		o_si = ~o_si;
		wt(10);
	endtask

	task automatic xb(input logic [7:0] b);
		for (int k = 7; k >= 0; k--) begin
			o_si = b[k];
			wt(4);
			// Sample at the rise; output settles about four cycles after a fall
			rx = {rx[6:0], i_so};
			o_sck = 1'b1;
			wt(4);
			o_sck = 1'b0;
		end
	endtask
endmodule // sfcmd_host

`default_nettype wire

/* File: verif/sfcmd_seq_test.sv */
/* Self-checking bench for the command sequencer with a host model.
   Assumes shortened erase times and arbitrary identity codes. */
`timescale 1ns/100ps
`default_nettype none

module sfcmd_seq_test;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wp_n = 1'b1;
	wire         cs_n, sck, si, so, so_oe, so_w, er_req, pr_req, bo_mode;
	wire  [1:0]  er_kind;
	wire  [23:0] er_addr, pr_addr;
	wire  [15:0] pr_data;
	wire  [7:0]  st;
	integer      errors = 0;
	integer      num_checks = 0;
	integer      seed = 32'h650a;
	logic [23:0] n_er = 24'h0;
	logic [23:0] n_pr = 24'h0;
	logic [23:0] a;
	logic [15:0] d;
	logic [7:0]  q[$];
	logic [7:0]  op[5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
	int          lsb[3] = '{12, 15, 16};
	localparam int T_PROG = 200;
	localparam int T_ERASE = 400;
	// Identity codes are arbitrary
	logic [7:0]  idv[9] = '{8'h5a, 8'h3c, 8'h14, 8'h5a, 8'h69, 8'h5a, 8'h69, 8'h69, 8'h5a};

	always #25 clk = ~clk;
	assign so_w = so_oe ? so : 1'bz;

	sfcmd_seq #(.BYTE_PROG_CYC(T_PROG), .SECTOR_CYC(T_ERASE), .BLOCK_CYC(T_ERASE),
		.ARRAY_CYC(T_ERASE)) sfcmd_seq_i (.i_clk(clk), .i_resetn(rst_n), .i_chip_sel_n(cs_n),
		.i_sck(sck), .i_si(si), .i_write_protect_n(wp_n), .o_so(so), .o_so_oe(so_oe),
		.o_erase_req(er_req), .o_erase_kind(er_kind), .o_erase_addr(er_addr),
		.o_prog_req(pr_req), .o_prog_addr(pr_addr), .o_prog_data(pr_data), .o_status(st),
		.o_busy_out_mode(bo_mode));
	sfcmd_host sfcmd_host_i (.i_clk(clk), .i_so(so_w), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));

	always @(posedge clk) begin
		n_er <= n_er + {23'h0, er_req};
		n_pr <= n_pr + {23'h0, pr_req};
	end

	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask

	// One frame: n bytes out of v, then m bytes read into q
	task automatic cmd(input logic [47:0] v, input int n, input int m = 0);
		sfcmd_host_i.sel();
		for (int j = n; j > 0; j--)
			sfcmd_host_i.xb(v[8*j-1 -: 8]);
		repeat (m) begin
			sfcmd_host_i.xb(8'h00);
			q.push_back(sfcmd_host_i.rx);
		end
		sfcmd_host_i.desel();
	endtask

	task automatic idle();
		for (int t = 0; t < 3000 && st[0] !== 1'b0; t++)
			@(negedge clk);
		chk(st[0], 24'h0);
	endtask

	task automatic wrst(input logic [7:0] v, input logic arm);
		cmd(arm ? 8'h50 : 8'h06, 1);
		cmd({8'h01, v}, 2);
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		chk(st, 24'h3c);
		chk(so_oe, 24'h0);
		cmd(8'h06, 1);
		chk(st[1], 24'h1);
		cmd({8'h20, 24'h001000}, 4);
		cmd(8'h60, 1);
		chk(n_er, 24'h0);
		wrst(8'h00, 1'b0);
		chk(st, 24'h00);
		$display("reset and protection done");
		for (int k = 0; k < 5; k++) begin
			a = 24'($random(seed)) & 24'h0effff;
			cmd(8'h06, 1);
			cmd(k < 3 ? {op[k], a} : {24'h0, op[k]}, k < 3 ? 4 : 1);
			chk(n_er, k[23:0] + 24'h1);
			chk(er_kind, k < 3 ? k[1:0] : 2'h3);
			if (k < 3)
				chk(er_addr, a & ~((24'h1 << lsb[k]) - 24'h1));
			cmd(8'h05, 1, 2);
			chk(q.pop_front(), 24'h01);
			chk(q.pop_front(), 24'h01);
			idle();
		end
		cmd({8'h20, a}, 4);
		chk(n_er, 24'h5);
		wrst(8'h04, 1'b0);
		chk(st, 24'h04);
		cmd(8'h06, 1);
		cmd({8'h20, 24'h0f8123}, 4);
		cmd(8'hc7, 1);
		chk(n_er, 24'h5);
		$display("erase done");
		cmd(8'h04, 1);
		wp_n = 1'b0;
		wrst(8'h84, 1'b1);
		chk(st, 24'h84);
		wrst(8'h00, 1'b1);
		chk(st, 24'h84);
		wp_n = 1'b1;
		wrst(8'h00, 1'b1);
		chk(st, 24'h00);
		cmd(8'h9f, 1, 3);
		cmd(32'h90000000, 4, 4);
		cmd(32'hab000001, 4, 2);
		foreach (idv[i])
			chk(q.pop_front(), idv[i]);
		$display("status and identity done");
		cmd(8'h70, 1);
		chk(bo_mode, 24'h1);
		a = 24'($random(seed)) & 24'h0efffe;
		d = 16'($random(seed));
		cmd(8'h06, 1);
		cmd({8'had, a, d}, 6);
		chk(n_pr, 24'h1);
		chk(pr_addr, a);
		chk(pr_data, d);
		chk(st[6:1], 24'h21);
		sfcmd_host_i.sel();
		chk(so_oe, 24'h1);
		chk(so, 24'h0);
		idle();
		sfcmd_host_i.wt(6);
		chk(so, 24'h1);
		sfcmd_host_i.desel();
		chk(so_oe, 24'h0);
		cmd({8'h20, a}, 4);
		chk(n_er, 24'h5);
		cmd({8'had, d}, 3);
		chk(pr_addr, a + 24'h2);
		cmd(8'h04, 1);
		chk(st[0], 24'h1);
		chk(st[6:1], 24'h00);
		idle();
		cmd(8'h80, 1);
		chk(bo_mode, 24'h0);
		$display("busy output done");
		wrap_up();
	end

	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		wrap_up();
	end
endmodule // sfcmd_seq_test

`default_nettype wire
